// *** bench/scfc_checker.sv ***
// port assertions for the fifo configuration block
`timescale 1ns/100ps
module scfc_checker #(parameter W = 8) (
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [7:0]   wb_adr_i,
   input wire logic [3:0]   wb_sel_i,
   input wire logic [31:0]  wb_dat_i,
   input wire logic         wb_ack_o,
   input wire logic         tx_valid_o,
   input wire logic         tx_ready_i,
   input wire logic         rx_ready_o,
   input wire logic         tx_enable_o,
   input wire logic         rx_enable_o,
   input wire logic         tx_irq_o,
   input wire logic         rx_irq_o,
   input wire logic [W-1:0] tx_data_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic auto_q;
   logic cfg_wr;
   logic mode_wr;
   assign cfg_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
   assign mode_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08;
   // shadow of the auto shutdown bit
   always @(posedge clk_i) begin
      if (rst_i)
         auto_q <= 1'b0;
      else if (cfg_wr)
         auto_q <= wb_dat_i[1];
   end
   chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_next: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given in the next cycle");
   chk_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !tx_enable_o && !rx_enable_o && !tx_irq_o && !rx_irq_o)
      else $error("outputs active after reset");
   chk_tx_irq_gate: assert property
      (tx_irq_o |-> tx_enable_o || $past(tx_enable_o))
      else $error("tx irq without tx enabled");
   chk_rx_irq_gate: assert property
      (rx_irq_o |-> rx_enable_o || $past(rx_enable_o))
      else $error("rx irq without rx enabled");
   chk_manual_only: assert property
      ($fell(tx_enable_o) && !auto_q && !$past(auto_q) |-> $past(mode_wr))
      else $error("tx enable cleared without auto shutdown");
   chk_tx_idle: assert property ((!tx_enable_o)[*3] |-> !tx_valid_o)
      else $error("tx valid while tx disabled");
   chk_rx_idle: assert property ((!rx_enable_o)[*3] |-> !rx_ready_o)
      else $error("rx ready while rx disabled");
   chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
      (tx_valid_o && $stable(tx_data_o)) || !tx_enable_o)
      else $error("tx byte dropped before taken");
endmodule
bind scfc_top scfc_checker #(.W(W)) u_chk (.*);

// *** bench/testbench.sv ***
// self-checking bench for the fifo configuration block
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   end end
module testbench;
   logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, txr = 0, txb = 0;
   logic        rxv = 0, tbf = 0, rsf = 0, rbf = 0;
   logic [7:0]  adr = 0, rxd = 8'h40;
   logic [31:0] wdat = 0, rdat;
   wire  [31:0] dat_o;
   wire  [7:0]  txd;
   wire         ack, txv, rxr, txe, rxe, tirq, rirq;
   int          num_errors = 0, comparisons = 0, cycles = 0;
   logic [7:0]  q[$];
   scfc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_data_o(txd),
      .tx_valid_o(txv), .tx_ready_i(txr), .tx_shift_busy_i(txb),
      .tx_buf_full_i(tbf), .rx_data_i(rxd), .rx_valid_i(rxv),
      .rx_ready_o(rxr), .rx_shift_full_i(rsf), .rx_buf_full_i(rbf),
      .tx_enable_o(txe), .rx_enable_o(rxe), .tx_irq_o(tirq),
      .rx_irq_o(rirq));
   initial forever #10 clk_i = ~clk_i;
   task report_and_stop;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         report_and_stop;
      end
   end
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(1'b0, a, 32'h0);
      `CHK(n, e, rdat)
   endtask
   task rx_feed(input int n);
      @(posedge clk_i);
      rxv <= 1'b1;
      repeat (n) begin
         @(posedge clk_i);
         rxd <= rxd + 8'h01;
      end
      rxv <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h0, "fcfg reset");
      rd(8'h08, 32'h0, "mode reset");
      wb(1'b1, 8'h00, 32'h0000001F);
      rd(8'h00, 32'h1F, "fcfg bits");
      rd(8'h20, 32'h0, "unmapped");
      $display("test registers done");
      wb(1'b1, 8'h00, 32'h09);
      wb(1'b1, 8'h08, 32'h0A);
      for (int i = 0; i < 5; i++) wb(1'b1, 8'h10, 32'hA0 + i);
      wb(1'b0, 8'h0C, 32'h0);
      `CHK("tx count", 3'h4, rdat[2:0])
      txr <= 1'b1;
      repeat (20) begin
         @(posedge clk_i);
         if (txv === 1'b1) q.push_back(txd);
      end
      txr <= 1'b0;
      `CHK("tx bytes", 5, q.size())
      for (int i = 0; i < 5; i++) `CHK("tx order", 8'hA0 + i, q[i])
      `CHK("tx irq on", 1'b1, tirq)
      `CHK("no auto clear", 1'b1, txe)
      wb(1'b1, 8'h00, 32'h01);
      repeat (3) @(posedge clk_i);
      `CHK("tx irq gated", 1'b0, tirq)
      txb <= 1'b1;
      wb(1'b1, 8'h00, 32'h03);
      repeat (4) @(posedge clk_i);
      `CHK("tx busy keeps", 1'b1, txe)
      txb <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK("tx auto off", 1'b0, txe)
      $display("test half transmit done");
      wb(1'b1, 8'h00, 32'h05);
      wb(1'b1, 8'h08, 32'h0F);
      for (int i = 0; i < 3; i++) wb(1'b1, 8'h10, 32'h50 + i);
      rx_feed(6);
      wb(1'b0, 8'h0C, 32'h0);
      `CHK("full tx count", 3'h2, rdat[2:0])
      `CHK("full rx count", 3'h2, rdat[10:8])
      `CHK("rx full ready", 1'b0, rxr)
      `CHK("rx irq on", 1'b1, rirq)
      rd(8'h10, 32'h40, "rx first byte");
      rd(8'h10, 32'h41, "rx second byte");
      wb(1'b1, 8'h04, 32'h01);
      wb(1'b1, 8'h00, 32'h11);
      wb(1'b1, 8'h08, 32'h0E);
      wb(1'b1, 8'h08, 32'h0F);
      rx_feed(6);
      wb(1'b0, 8'h0C, 32'h0);
      `CHK("rx usage", 3'h1, rdat[10:8])
      `CHK("rx irq gated", 1'b0, rirq)
      $display("test full duplex done");
      wb(1'b1, 8'h08, 32'h0);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h00, 32'h03);
      wb(1'b1, 8'h08, 32'h05);
      rbf <= 1'b1;
      rx_feed(2);
      `CHK("rx below count", 1'b1, rxe)
      rx_feed(4);
      `CHK("rx auto off", 1'b0, rxe)
      rbf <= 1'b0;
      wb(1'b1, 8'h08, 32'h0F);
      repeat (4) @(posedge clk_i);
      `CHK("full tx off", 1'b0, txe)
      `CHK("full rx off", 1'b0, rxe)
      $display("test auto shutdown done");
      report_and_stop;
   end
endmodule

// *** design/scfc_defines.vh ***
// register map, field positions, reset values and fifo sizing constants
`ifndef SCFC_DEFINES_VH
`define SCFC_DEFINES_VH

`define SCFC_OFS_FCFG      8'h00
`define SCFC_OFS_RXCFG     8'h04
`define SCFC_OFS_MODE      8'h08
`define SCFC_OFS_STAT      8'h0C
`define SCFC_OFS_DATA      8'h10

`define SCFC_FCFG_EN       0
`define SCFC_FCFG_AUTO     1
`define SCFC_FCFG_RXGATE   2
`define SCFC_FCFG_TXGATE   3
`define SCFC_FCFG_USAGE    4
`define SCFC_FCFG_RST      8'h00

`define SCFC_RXCFG_LVL_LSB 0
`define SCFC_RXCFG_RST     2'h0

`define SCFC_MODE_RXE      0
`define SCFC_MODE_TXE      1
`define SCFC_MODE_DPX_LSB  2
`define SCFC_MODE_RST      4'h0

`define SCFC_DPX_OFF       2'h0
`define SCFC_DPX_HALF_RX   2'h1
`define SCFC_DPX_HALF_TX   2'h2
`define SCFC_DPX_FULL      2'h3

`define SCFC_SIZE_HALF     3'h4
`define SCFC_SIZE_FULL     3'h2
`define SCFC_SIZE_NOFIFO   3'h1

`endif

// *** design/scfc_fifo.v ***
// byte fifo with a run-time capacity limit and flush
`timescale 1ns/100ps
module scfc_fifo #(
   parameter W     = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          flush_i,
   input  wire [AW:0]   limit_i,
   input  wire          wr_valid_i,
   output wire          wr_ready_o,
   input  wire [W-1:0]  wr_data_i,
   output wire          rd_valid_o,
   input  wire          rd_ready_i,
   output wire [W-1:0]  rd_data_o,
   output wire [AW:0]   count_o
);
   reg  [W-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr_reg;
   reg  [AW-1:0] rd_ptr_reg;
   reg  [AW:0]   count_reg;
   wire          push;
   wire          pop;

   assign wr_ready_o = (count_reg < limit_i) && !flush_i;
   assign rd_valid_o = (count_reg != {(AW+1){1'b0}});
   assign rd_data_o  = mem[rd_ptr_reg];
   assign count_o    = count_reg;
   assign push       = wr_valid_i && wr_ready_o;
   assign pop        = rd_valid_o && rd_ready_i && !flush_i;

   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= wr_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// *** design/scfc_top.v ***
// serial channel fifo configuration with tx/rx fifos and wishbone slave
`timescale 1ns/100ps
`include "scfc_defines.vh"

module scfc_top #(
   parameter W     = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [7:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output wire [31:0]   wb_dat_o,
   output wire          wb_ack_o,
   output wire [W-1:0]  tx_data_o,
   output wire          tx_valid_o,
   input  wire          tx_ready_i,
   input  wire          tx_shift_busy_i,
   input  wire          tx_buf_full_i,
   input  wire [W-1:0]  rx_data_i,
   input  wire          rx_valid_i,
   output wire          rx_ready_o,
   input  wire          rx_shift_full_i,
   input  wire          rx_buf_full_i,
   output wire          tx_enable_o,
   output wire          rx_enable_o,
   output wire          tx_irq_o,
   output wire          rx_irq_o
);
   reg  [7:0]    fifo_configuration_reg;
   reg  [1:0]    rx_fifo_config_reg;
   reg  [3:0]    mode_reg;
   reg           ack_reg;
   reg  [31:0]   dat_reg;
   reg  [W-1:0]  tx_data_reg;
   reg           tx_valid_reg;
   reg           rx_ready_reg;
   reg           tx_irq_reg;
   reg           rx_irq_reg;
   reg  [31:0]   rdata;
   reg  [AW:0]   tx_limit;
   reg  [AW:0]   rx_max;
   reg  [3:0]    mode_next;

   wire          fifo_en;
   wire          auto_transfer_shutdown;
   wire          rx_fifo_irq_gate;
   wire          tx_fifo_irq_gate;
   wire          rx_fifo_usage_select;
   wire [1:0]    duplex;
   wire          rx_on;
   wire          tx_on;
   wire [AW:0]   fill_level;
   wire [AW:0]   rx_limit;
   wire          bus_req;
   wire          wr_now;
   wire          rd_now;
   wire          wr_cfg;
   wire          hit_data;
   wire          tx_push;
   wire          tx_wr_ready;
   wire          tx_rd_valid;
   wire [W-1:0]  tx_rd_data;
   wire          tx_pop;
   wire [AW:0]   tx_count;
   wire          rx_rd_valid;
   wire [W-1:0]  rx_rd_data;
   wire          rx_pop;
   wire [AW:0]   rx_count;
   wire          rx_push;
   wire [AW+2:0] rx_held;
   wire          rx_full_cond;
   wire          tx_empty_cond;
   wire [AW+1:0] rx_next;

   assign fifo_en                = fifo_configuration_reg[`SCFC_FCFG_EN];
   assign auto_transfer_shutdown = fifo_configuration_reg[`SCFC_FCFG_AUTO];
   assign rx_fifo_irq_gate       = fifo_configuration_reg[`SCFC_FCFG_RXGATE];
   assign tx_fifo_irq_gate       = fifo_configuration_reg[`SCFC_FCFG_TXGATE];
   assign rx_fifo_usage_select   = fifo_configuration_reg[`SCFC_FCFG_USAGE];
   assign duplex = mode_reg[`SCFC_MODE_DPX_LSB+1:`SCFC_MODE_DPX_LSB];
   assign rx_on  = mode_reg[`SCFC_MODE_RXE];
   assign tx_on  = mode_reg[`SCFC_MODE_TXE];

   // fill level 0 stands for the whole configured depth
   assign fill_level = (rx_fifo_config_reg == 2'h0) ? rx_max :
                       {{(AW-1){1'b0}}, rx_fifo_config_reg};
   assign rx_limit = (rx_fifo_usage_select && fifo_en) ?
                     ((fill_level < rx_max) ? fill_level : rx_max) : rx_max;

   // fifo sizes follow the duplex setting once the fifo is enabled
   always @* begin
      tx_limit = `SCFC_SIZE_NOFIFO;
      rx_max   = `SCFC_SIZE_NOFIFO;
      if (fifo_en) begin
         case (duplex)
            `SCFC_DPX_HALF_RX: begin
               rx_max   = `SCFC_SIZE_HALF;
               tx_limit = `SCFC_SIZE_NOFIFO;
            end
            `SCFC_DPX_HALF_TX: begin
               tx_limit = `SCFC_SIZE_HALF;
               rx_max   = `SCFC_SIZE_NOFIFO;
            end
            `SCFC_DPX_FULL: begin
               tx_limit = `SCFC_SIZE_FULL;
               rx_max   = `SCFC_SIZE_FULL;
            end
            default: begin
               tx_limit = `SCFC_SIZE_NOFIFO;
               rx_max   = `SCFC_SIZE_NOFIFO;
            end
         endcase
      end
   end

   // wishbone classic: ack one cycle after the strobe, effects at ack edge
   assign bus_req  = wb_cyc_i && wb_stb_i;
   assign wr_now   = bus_req && ack_reg && wb_we_i;
   assign rd_now   = bus_req && ack_reg && !wb_we_i;
   assign hit_data = (wb_adr_i == `SCFC_OFS_DATA);
   assign wr_cfg   = wr_now && wb_sel_i[0];
   assign tx_push  = wr_cfg && hit_data;
   assign rx_pop   = rd_now && hit_data && rx_rd_valid;

   scfc_fifo #(
      .W     (W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_tx_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .flush_i    (!tx_on),
      .limit_i    (tx_limit),
      .wr_valid_i (tx_push),
      .wr_ready_o (tx_wr_ready),
      .wr_data_i  (wb_dat_i[W-1:0]),
      .rd_valid_o (tx_rd_valid),
      .rd_ready_i (tx_pop),
      .rd_data_o  (tx_rd_data),
      .count_o    (tx_count)
   );

   scfc_fifo #(
      .W     (W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_rx_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .flush_i    (!rx_on),
      .limit_i    (rx_limit),
      .wr_valid_i (rx_push),
      .wr_ready_o (),
      .wr_data_i  (rx_data_i),
      .rd_valid_o (rx_rd_valid),
      .rd_ready_i (rx_pop),
      .rd_data_o  (rx_rd_data),
      .count_o    (rx_count)
   );

   // output stage toward the transmit shifter refills when empty or taken
   assign tx_pop  = tx_rd_valid && (!tx_valid_reg || tx_ready_i);
   assign rx_push = rx_valid_i && rx_ready_reg;
   assign rx_next = {1'b0, rx_count} + {{(AW+1){1'b0}}, rx_push}
                    - {{(AW+1){1'b0}}, rx_pop};

   // bytes held in shifter, buffer and fifo versus the selected count
   assign rx_held = {2'b00, rx_count} + {{(AW+2){1'b0}}, rx_shift_full_i}
                    + {{(AW+2){1'b0}}, rx_buf_full_i};
   assign rx_full_cond  = fifo_en && rx_on &&
                          (rx_held >= {2'b00, rx_limit});
   assign tx_empty_cond = fifo_en && tx_on && !tx_rd_valid &&
                          !tx_valid_reg && !tx_shift_busy_i &&
                          !tx_buf_full_i;

   // hardware shutdown first, a software write in the same cycle wins
   always @* begin
      mode_next = mode_reg;
      if (auto_transfer_shutdown) begin
         case (duplex)
            `SCFC_DPX_HALF_RX: begin
               if (rx_full_cond) begin
                  mode_next[`SCFC_MODE_RXE] = 1'b0;
               end
            end
            `SCFC_DPX_HALF_TX: begin
               if (tx_empty_cond) begin
                  mode_next[`SCFC_MODE_TXE] = 1'b0;
               end
            end
            `SCFC_DPX_FULL: begin
               if (rx_full_cond || tx_empty_cond) begin
                  mode_next[`SCFC_MODE_RXE] = 1'b0;
                  mode_next[`SCFC_MODE_TXE] = 1'b0;
               end
            end
            default: begin
               mode_next = mode_reg;
            end
         endcase
      end
      if (wr_cfg && (wb_adr_i == `SCFC_OFS_MODE)) begin
         mode_next = wb_dat_i[3:0];
      end
   end

   always @* begin
      rdata = 32'h0000_0000;
      case (wb_adr_i)
         `SCFC_OFS_FCFG: rdata[7:0] = fifo_configuration_reg;
         `SCFC_OFS_RXCFG: rdata[1:0] = rx_fifo_config_reg;
         `SCFC_OFS_MODE: rdata[3:0] = mode_reg;
         `SCFC_OFS_STAT: begin
            rdata[AW:0]   = tx_count;
            rdata[AW+8:8] = rx_count;
            rdata[16]     = tx_wr_ready;
            rdata[17]     = rx_rd_valid;
            rdata[18]     = tx_empty_cond;
            rdata[19]     = rx_full_cond;
         end
         `SCFC_OFS_DATA: rdata[W-1:0] = rx_rd_valid ? rx_rd_data :
                                       {W{1'b0}};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         fifo_configuration_reg <= `SCFC_FCFG_RST;
         rx_fifo_config_reg     <= `SCFC_RXCFG_RST;
         mode_reg               <= `SCFC_MODE_RST;
         ack_reg                <= 1'b0;
         dat_reg                <= 32'h0000_0000;
      end else begin
         ack_reg  <= bus_req && !ack_reg;
         dat_reg  <= rdata;
         mode_reg <= mode_next;
         if (wr_cfg && (wb_adr_i == `SCFC_OFS_FCFG)) begin
            // bits 7..5 are stored as written; software keeps them zero
            fifo_configuration_reg <= wb_dat_i[7:0];
         end
         if (wr_cfg && (wb_adr_i == `SCFC_OFS_RXCFG)) begin
            rx_fifo_config_reg <= wb_dat_i[1:0];
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_data_reg  <= {W{1'b0}};
         tx_valid_reg <= 1'b0;
         rx_ready_reg <= 1'b0;
         tx_irq_reg   <= 1'b0;
         rx_irq_reg   <= 1'b0;
      end else begin
         if (!tx_on) begin
            tx_valid_reg <= 1'b0;
         end else if (tx_pop) begin
            tx_data_reg  <= tx_rd_data;
            tx_valid_reg <= 1'b1;
         end else if (tx_ready_i) begin
            tx_valid_reg <= 1'b0;
         end
         rx_ready_reg <= mode_next[`SCFC_MODE_RXE] &&
                         (rx_next < {1'b0, rx_limit});
         tx_irq_reg <= fifo_en && tx_fifo_irq_gate && tx_on &&
                       !tx_rd_valid;
         rx_irq_reg <= fifo_en && rx_fifo_irq_gate && rx_on &&
                       (rx_count >= fill_level);
      end
   end

   assign wb_ack_o    = ack_reg;
   assign wb_dat_o    = dat_reg;
   assign tx_data_o   = tx_data_reg;
   assign tx_valid_o  = tx_valid_reg;
   assign rx_ready_o  = rx_ready_reg;
   assign tx_enable_o = mode_reg[`SCFC_MODE_TXE];
   assign rx_enable_o = mode_reg[`SCFC_MODE_RXE];
   assign tx_irq_o    = tx_irq_reg;
   assign rx_irq_o    = rx_irq_reg;
endmodule
